//--- common/icdp_cfg.svh
// constants for the data and command port: offsets, fields, sizes
`ifndef ICDP_CFG_SVH
`define ICDP_CFG_SVH

// ===========================================================
// register map
`define ICDP_APB_AW        8
`define ICDP_OFS_DATA      8'h10
`define ICDP_OFS_DATA_HI   8'h11

// ===========================================================
// command word fields
`define ICDP_BIT_READ      8
`define ICDP_BIT_STOP      9
`define ICDP_BIT_RESTART   10
`define ICDP_BIT_FIRST     11
`define ICDP_BYTE_MSB      7
`define ICDP_CMD_W         11
`define ICDP_CMD_W_NOHOLD  9
`define ICDP_RX_W          9
`define ICDP_RD_W          12

// ===========================================================
// queue sizes and reset values
`define ICDP_FIFO_AW       4
`define ICDP_RST_WORD      32'h0000_0000
`define ICDP_RST_BYTE      8'h00

`endif

//--- common/icdp_pkg.sv
// types shared by the data and command port
package icdp_pkg;

  // ===========================================================
  // command sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_FETCH,
    SEQ_BUSY,
    SEQ_DRAIN
  } icdp_seq_t;

endpackage : icdp_pkg

//--- src/icdp_fifo_mem.sv
// small queue memory with registered read data
`timescale 1ns/1ns
`include "icdp_cfg.svh"

module icdp_fifo_mem #(
  parameter int WIDTH  = `ICDP_CMD_W,
  parameter int ADDR_W = `ICDP_FIFO_AW
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              clkEn,
  input  wire logic              wrEn,
  input  wire logic [WIDTH-1:0]  wrData,
  input  wire logic              rdEn,
  output logic      [WIDTH-1:0]  rdData,
  output logic      [ADDR_W:0]   count
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W:0] FULL_CNT = (ADDR_W+1)'(DEPTH);

  logic [WIDTH-1:0]  mem [DEPTH];
  logic [ADDR_W-1:0] wrPtr;
  logic [ADDR_W-1:0] rdPtr;
  logic [ADDR_W-1:0] next_wrPtr;
  logic [ADDR_W-1:0] next_rdPtr;
  logic [ADDR_W:0]   next_count;
  logic [WIDTH-1:0]  next_rdData;
  logic              doWr;
  logic              doRd;

  // ===========================================================
  // pointer arithmetic; a write into a full queue is dropped
  always_comb begin
    doWr        = wrEn && (count != FULL_CNT);
    doRd        = rdEn && (count != '0);
    next_wrPtr  = doWr ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr  = doRd ? rdPtr + 1'b1 : rdPtr;
    next_rdData = doRd ? mem[rdPtr] : rdData;
    next_count  = count;
    if (doWr && !doRd) begin
      next_count = count + 1'b1;
    end else if (doRd && !doWr) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wrPtr  <= '0;
      rdPtr  <= '0;
      count  <= '0;
      rdData <= '0;
    end else if (clkEn) begin
      wrPtr  <= next_wrPtr;
      rdPtr  <= next_rdPtr;
      count  <= next_count;
      rdData <= next_rdData;
    end
  end

  // storage has no reset: contents are only read behind count
  always_ff @(posedge ref_clk) begin
    if (clkEn && doWr) begin
      mem[wrPtr] <= wrData;
    end
  end

endmodule : icdp_fifo_mem

//--- src/icdp_data_cmd_port.sv
// data and command port: apb register, queues, start/restart/stop choice
`timescale 1ns/1ns
`include "icdp_cfg.svh"

// Functional notes
// - offset 0x10: write queues command, read pops byte
// - command word 11 bits with hold, else 9
// - read word 12 bits with status, else 8
// - bit 11 marks first byte after address
// - byte read 0x10, optional status read 0x11
// - restart bit forces repeated start when enabled
// - otherwise restart only on direction change
// - restart disabled: stop then start instead
// - stop bit: stop after byte, then rearbitrate
// - empty queue without stop: hold clock low with hold, else stop
// - restart and stop bits apply once, reset zero
// - bit 8 picks master read or write
// - bits 7:0 carry write byte or received byte
module icdp_data_cmd_port (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  // static options
  input  wire logic        emptyFifoHoldOption,
  input  wire logic        firstByteStatusOption,
  input  wire logic        restartGenerationEnable,
  // register port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [`ICDP_APB_AW-1:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // bus controller side
  output logic             engValid,
  output logic             engStart,
  output logic             engRestart,
  output logic             engStopStart,
  output logic             engRead,
  output logic      [7:0]  engByte,
  output logic             engStopAfter,
  output logic             engStopOnly,
  output logic             engHoldScl,
  output logic             engAckRead,
  input  wire logic        engDone,
  input  wire logic        engLost,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxFirst
);

  localparam int AW = `ICDP_FIFO_AW;

  // ===========================================================
  // helpers
  // read word layout, used for the pop and for the status latch
  function automatic logic [31:0] rdWord(
    input logic [`ICDP_RX_W-1:0] entry,
    input logic                  statusOpt
  );
    logic [31:0] w;
    w = `ICDP_RST_WORD;
    w[`ICDP_BYTE_MSB:0] = entry[`ICDP_BYTE_MSB:0];
    w[`ICDP_BIT_FIRST]  = statusOpt && entry[`ICDP_RX_W-1];
    return w;
  endfunction : rdWord

  // ===========================================================
  // queues
  logic                    txWr;
  logic                    txRd;
  logic [`ICDP_CMD_W-1:0]  txIn;
  logic [`ICDP_CMD_W-1:0]  txData;
  logic [AW:0]             txCount;
  logic                    rxRd;
  logic [`ICDP_RX_W-1:0]   rxData;
  logic [AW:0]             rxCount;

  icdp_fifo_mem #(.WIDTH(`ICDP_CMD_W), .ADDR_W(AW)) txQueue (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .wrEn    (txWr),
    .wrData  (txIn),
    .rdEn    (txRd),
    .rdData  (txData),
    .count   (txCount)
  );

  // received bytes carry their first-byte mark beside them
  icdp_fifo_mem #(.WIDTH(`ICDP_RX_W), .ADDR_W(AW)) rxQueue (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .wrEn    (rxValid),
    .wrData  ({rxFirst, rxByte}),
    .rdEn    (rxRd),
    .rdData  (rxData),
    .count   (rxCount)
  );

  // ===========================================================
  // register port
  logic        rdPend;
  logic [31:0] lastWord;
  logic        next_rdPend;
  logic [31:0] next_lastWord;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        setupRd;
  logic        accessPh;
  logic        hitData;
  logic        hitHigh;

  always_comb begin
    hitData  = (paddr == `ICDP_OFS_DATA);
    hitHigh  = (paddr == `ICDP_OFS_DATA_HI);
    setupRd  = psel && !penable && !pwrite;
    accessPh = psel && penable && !pready;
    // pop in the setup phase so the data is out of the memory by access
    rxRd = setupRd && hitData && (rxCount != '0);
    // write lands when the access completes
    txWr = psel && penable && pready && pwrite && hitData;
    txIn = pwdata[`ICDP_CMD_W-1:0];
    if (!emptyFifoHoldOption) begin
      // narrow word: the one-shot restart and stop bits do not exist
      txIn[`ICDP_BIT_RESTART] = 1'b0;
      txIn[`ICDP_BIT_STOP]    = 1'b0;
    end
    next_rdPend   = setupRd ? rxRd : rdPend;
    next_lastWord = lastWord;
    next_prdata   = prdata;
    next_pready   = accessPh;
    next_pslverr  = 1'b0;
    if (accessPh) begin
      next_prdata = `ICDP_RST_WORD;
      if (!pwrite && hitData) begin
        if (rdPend) begin
          next_prdata   = rdWord(rxData, firstByteStatusOption);
          next_lastWord = next_prdata;
        end
      end else if (!pwrite && hitHigh) begin
        // second narrow read: no pop, shows status of the byte just read
        next_prdata[7:0] = lastWord[15:8];
      end else if (!hitData) begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdPend   <= 1'b0;
      lastWord <= `ICDP_RST_WORD;
      prdata   <= `ICDP_RST_WORD;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else if (clkEn) begin
      rdPend   <= next_rdPend;
      lastWord <= next_lastWord;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
    end
  end

  // ===========================================================
  // command sequencer
  icdp_pkg::icdp_seq_t state;
  icdp_pkg::icdp_seq_t next_state;
  logic       busActive;
  logic       prevRead;
  logic       next_busActive;
  logic       next_prevRead;
  logic       next_engValid;
  logic       next_engStart;
  logic       next_engRestart;
  logic       next_engStopStart;
  logic       next_engRead;
  logic [7:0] next_engByte;
  logic       next_engStopAfter;
  logic       next_engStopOnly;
  logic       next_engHoldScl;
  logic       next_engAckRead;
  logic       needRestart;
  logic       cmdRead;

  always_comb begin
    next_state        = state;
    next_busActive    = busActive;
    next_prevRead     = prevRead;
    next_engValid     = 1'b0;
    next_engStart     = engStart;
    next_engRestart   = engRestart;
    next_engStopStart = engStopStart;
    next_engRead      = engRead;
    next_engByte      = engByte;
    next_engStopAfter = engStopAfter;
    next_engStopOnly  = 1'b0;
    next_engHoldScl   = 1'b0;
    next_engAckRead   = engAckRead;
    txRd              = 1'b0;
    cmdRead           = txData[`ICDP_BIT_READ];
    needRestart       = txData[`ICDP_BIT_RESTART]
                        || (cmdRead != prevRead);
    case (state)
      icdp_pkg::SEQ_IDLE: begin
        if (txCount != '0) begin
          // one head at a time keeps the written order
          txRd       = 1'b1;
          next_state = icdp_pkg::SEQ_FETCH;
        end else if (busActive && emptyFifoHoldOption) begin
          next_engHoldScl = 1'b1;
        end else if (busActive) begin
          // without the hold option a dry queue ends the transfer
          next_engStopOnly = 1'b1;
          next_state       = icdp_pkg::SEQ_DRAIN;
        end
      end
      icdp_pkg::SEQ_FETCH: begin
        next_engValid     = 1'b1;
        next_engRead      = cmdRead;
        next_engByte      = txData[`ICDP_BYTE_MSB:0];
        // flags are taken from this command only
        next_engStopAfter = txData[`ICDP_BIT_STOP];
        next_engStart     = !busActive;
        next_engRestart   = busActive && needRestart
                            && restartGenerationEnable;
        next_engStopStart = busActive && needRestart
                            && !restartGenerationEnable;
        next_engAckRead   = cmdRead && !txData[`ICDP_BIT_STOP]
                            && (txCount != '0);
        next_prevRead     = cmdRead;
        next_busActive    = 1'b1;
        next_state        = icdp_pkg::SEQ_BUSY;
      end
      icdp_pkg::SEQ_BUSY: begin
        // ack decision follows the queue while the byte is on the wire
        next_engAckRead = engRead && !engStopAfter
                          && (txCount != '0);
        if (engLost) begin
          next_busActive = 1'b0;
          next_state     = icdp_pkg::SEQ_IDLE;
        end else if (engDone) begin
          if (engStopAfter) begin
            next_busActive = 1'b0;
          end
          next_state = icdp_pkg::SEQ_IDLE;
        end
      end
      icdp_pkg::SEQ_DRAIN: begin
        if (engDone || engLost) begin
          next_busActive = 1'b0;
          next_state     = icdp_pkg::SEQ_IDLE;
        end
      end
      default: begin
        next_state = icdp_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state        <= icdp_pkg::SEQ_IDLE;
      busActive    <= 1'b0;
      prevRead     <= 1'b0;
      engValid     <= 1'b0;
      engStart     <= 1'b0;
      engRestart   <= 1'b0;
      engStopStart <= 1'b0;
      engRead      <= 1'b0;
      engByte      <= `ICDP_RST_BYTE;
      engStopAfter <= 1'b0;
      engStopOnly  <= 1'b0;
      engHoldScl   <= 1'b0;
      engAckRead   <= 1'b0;
    end else if (clkEn) begin
      state        <= next_state;
      busActive    <= next_busActive;
      prevRead     <= next_prevRead;
      engValid     <= next_engValid;
      engStart     <= next_engStart;
      engRestart   <= next_engRestart;
      engStopStart <= next_engStopStart;
      engRead      <= next_engRead;
      engByte      <= next_engByte;
      engStopAfter <= next_engStopAfter;
      engStopOnly  <= next_engStopOnly;
      engHoldScl   <= next_engHoldScl;
      engAckRead   <= next_engAckRead;
    end
  end

endmodule : icdp_data_cmd_port

//--- sim/icdp_data_cmd_port_properties.sv
// pin-level assertions for the data and command port
`timescale 1ns/1ns
module icdp_port_checker (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       emptyFifoHoldOption,
  input wire logic       restartGenerationEnable,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       engValid,
  input wire logic       engStart,
  input wire logic       engRestart,
  input wire logic       engStopStart,
  input wire logic       engRead,
  input wire logic [7:0] engByte,
  input wire logic       engStopOnly,
  input wire logic       engHoldScl,
  input wire logic       engStopAfter,
  input wire logic       engAckRead,
  input wire logic       engDone
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ===========================================================
  // register port
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  // ===========================================================
  // command sequencing
  a_valid_pulse: assert property (engValid |=> !engValid)
    else $error("command pulse longer than one cycle");
  a_done_gap: assert property (engDone |=> !engValid [*2])
    else $error("next command too soon after done");
  a_one_opening: assert property (engValid |->
    !(engRestart && engStopStart) && !(engStart && engRestart))
    else $error("more than one opening condition");
  a_restart_en: assert property (engValid && engRestart |->
    restartGenerationEnable)
    else $error("repeated start while disabled");
  a_stop_start: assert property (engValid && engStopStart |->
    !restartGenerationEnable)
    else $error("stop and start while restart enabled");
  a_hold_opt: assert property (engHoldScl |-> emptyFifoHoldOption)
    else $error("clock hold without hold option");
  a_stop_only: assert property (engStopOnly |->
    !emptyFifoHoldOption ##1 !engStopOnly)
    else $error("bad stop-only pulse");
  a_flags_hold: assert property (!engValid |->
    $stable(engByte) && $stable(engRead))
    else $error("command fields moved between commands");
  a_ack_read: assert property (engAckRead |->
    engRead && !engStopAfter)
    else $error("acknowledge without a pending read");
  c_ack: cover property (engAckRead);
  c_restart: cover property (engValid && engRestart);
  c_stop_start: cover property (engValid && engStopStart);
  c_hold: cover property (engHoldScl);
endmodule : icdp_port_checker

bind icdp_data_cmd_port icdp_port_checker u_chk (.ref_clk, .rst_b,
  .emptyFifoHoldOption, .restartGenerationEnable, .psel, .penable,
  .pready, .pslverr, .engValid, .engStart, .engRestart, .engStopStart,
  .engRead, .engByte, .engStopOnly, .engHoldScl, .engStopAfter,
  .engAckRead, .engDone);

//--- sim/icdp_engine_model.sv
// bus controller stand-in: finishes each command after a short or long delay
`timescale 1ns/1ns
module icdp_engine_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       slowMode,
  input  wire logic       engValid,
  input  wire logic       engRead,
  input  wire logic       engStart,
  input  wire logic       engRestart,
  input  wire logic       engStopStart,
  input  wire logic       engStopOnly,
  output logic            engDone,
  output logic            engLost,
  output logic            rxValid,
  output logic [7:0]      rxByte,
  output logic            rxFirst
);
  logic [3:0] waitCnt;
  logic       busy;
  logic       isRead;
  logic       isFirst;
  logic [7:0] nRx;
  // ===========================================================
  // answer logic; rx lines churn outside valid so stale data is caught
  always @(posedge ref_clk) begin
    engDone <= 1'b0;
    engLost <= 1'b0;
    rxValid <= 1'b0;
    rxByte  <= ~rxByte;
    rxFirst <= ~rxFirst;
    if (!rst_b) begin
      busy    <= 1'b0;
      nRx     <= 8'h00;
      rxByte  <= 8'h00;
      rxFirst <= 1'b0;
    end else if (!busy && (engValid || engStopOnly)) begin
      busy    <= 1'b1;
      waitCnt <= slowMode ? 4'h7 : 4'h1;
      isRead  <= engValid & engRead;
      isFirst <= engStart | engRestart | engStopStart;
    end else if (busy && waitCnt != 4'h0) begin
      waitCnt <= waitCnt - 4'h1;
    end else if (busy) begin
      busy    <= 1'b0;
      engDone <= 1'b1;
      if (isRead) begin
        rxValid <= 1'b1;
        rxByte  <= 8'hA0 + nRx;
        rxFirst <= isFirst;
        nRx     <= nRx + 8'h01;
      end
    end
  end
endmodule : icdp_engine_model

//--- sim/icdp_data_cmd_port_tb.sv
// self-checking bench for the data and command port
`timescale 1ns/1ns
module icdp_data_cmd_port_tb;
  logic        ref_clk = 0, rst_b = 0, holdOpt = 1, statOpt = 1;
  logic        rstEn = 1, slowMode = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, engByte, rxByte, nRx;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, engValid, engStart, engRestart, engRead;
  logic        engStopStart, engStopAfter, engStopOnly, engHoldScl;
  logic        engAckRead, engDone, engLost, rxValid, rxFirst;
  logic        busOpen, prevDir, stopSeen;
  int          miscompares = 0, n_tests = 0, seed = 33;
  logic [33:0] apbQ[$];
  logic [12:0] engQ[$];
  logic [8:0]  rxQ[$];
  always #5 ref_clk = ~ref_clk;
  icdp_data_cmd_port DUT (.ref_clk, .rst_b, .clkEn(1'b1),
    .emptyFifoHoldOption(holdOpt), .firstByteStatusOption(statOpt),
    .restartGenerationEnable(rstEn), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .engValid, .engStart, .engRestart,
    .engStopStart, .engRead, .engByte, .engStopAfter, .engStopOnly,
    .engHoldScl, .engAckRead, .engDone, .engLost, .rxValid, .rxByte,
    .rxFirst);
  icdp_engine_model MDL (.ref_clk, .rst_b, .slowMode, .engValid, .engRead,
    .engStart, .engRestart, .engStopStart, .engStopOnly, .engDone,
    .engLost, .rxValid, .rxByte, .rxFirst);
  // ===========================================================
  // tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [33:0] e);
    int i;
    apbQ.push_back(e);
    @(negedge ref_clk);
    psel = 1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge ref_clk);
    penable = 1;
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 8) begin
      miscompares++;
      report_and_stop();
    end
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic cmd(logic [10:0] w);
    logic rd, rs, sp, ch;
    rd = w[8];
    rs = holdOpt & w[10];
    sp = holdOpt & w[9];
    ch = busOpen & (rs | (rd != prevDir));
    engQ.push_back({!busOpen, ch & rstEn, ch & !rstEn, rd, sp, w[7:0]});
    if (rd) rxQ.push_back({!busOpen | ch, 8'hA0 + nRx});
    if (rd) nRx++;
    busOpen = holdOpt & !sp;
    prevDir = rd;
    stopSeen = 0;
    apb(1, 8'h10, {21'($random(seed)), w}, 34'h0);
  endtask : cmd
  task automatic settle();
    int i;
    // a hold left over from a dry spell must not end the wait early
    for (i = 0; i < 300 && !(engQ.size() == 0
         && (holdOpt ? engHoldScl : stopSeen)); i++)
      @(negedge ref_clk);
    if (i == 300) begin
      miscompares++;
      report_and_stop();
    end
    check("engAckRead", 32'h0, 32'(engAckRead));
  endtask : settle
  task automatic drain();
    logic [8:0] x;
    logic [31:0] e;
    while (rxQ.size() > 0) begin
      x = rxQ.pop_front();
      e = statOpt ? {20'h0, x[8], 3'h0, x[7:0]} : {24'h0, x[7:0]};
      apb(0, 8'h10, 32'h0, {2'b10, e});
      apb(0, 8'h11, 32'h0, {2'b10, 24'h0, e[15:8]});
    end
  endtask : drain
  // options move only while reset is held, never under a live hold
  task automatic do_reset(logic h, logic s, logic r, logic sl);
    @(negedge ref_clk);
    rst_b = 0;
    holdOpt = h;
    statOpt = s;
    rstEn = r;
    slowMode = sl;
    repeat (20) @(negedge ref_clk);
    rst_b = 1;
    busOpen = 0;
    prevDir = 0;
    nRx = 8'h00;
  endtask : do_reset
  // ===========================================================
  // watcher: oldest note against each result
  always @(posedge ref_clk) begin : watch
    logic [33:0] a;
    logic [12:0] c;
    if (engStopOnly === 1'b1) stopSeen = 1;
    if (rst_b && pready === 1'b1 && apbQ.size() > 0) begin
      a = apbQ.pop_front();
      check("pslverr", 32'(a[32]), 32'(pslverr));
      if (a[33]) check("prdata", a[31:0], prdata);
    end
    if (rst_b && engValid === 1'b1) begin
      if (engQ.size() == 0) check("extra command", 32'h0, 32'h1);
      else begin
        c = engQ.pop_front();
        check("openings", 32'(c[12:8]), 32'({engStart, engRestart,
          engStopStart, engRead, engStopAfter}));
        if (!c[9]) check("engByte", 32'(c[7:0]), 32'(engByte));
      end
    end
  end
  // ===========================================================
  // main sequence
  initial begin
    do_reset(1, 1, 1, 0);
    apb(0, 8'h10, 32'h0, {2'b10, 32'h0});
    apb(0, 8'h14, 32'h0, {2'b01, 32'h0});
    apb(1, 8'h11, 32'h0, {2'b01, 32'h0});
    for (int m = 0; m < 4; m++) begin
      do_reset(1, 1, m[0], m[1]);
      repeat (10) cmd(11'($random(seed)));
      cmd(11'h100);
      settle();
      drain();
    end
    do_reset(0, 0, 1, 1);
    for (int k = 0; k < 4; k++) begin
      cmd(11'($random(seed)));
      settle();
      busOpen = 0;
      drain();
    end
    report_and_stop();
  end
endmodule : icdp_data_cmd_port_tb
